//--- logic/bfs_sequencer.sv
// Gate-drive sequencing, current-limit reaction and hiccup protection with APB registers
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "bfs_cfg.svh"
module bfs_sequencer import bfs_pkg::*; #(
  parameter int HICCUP_CYCLES = `BFS_HICCUP_SW_CYCLES,
  parameter int SS_STEPS = `BFS_SS_STEPS,
  parameter int SS_CYCLES = `BFS_SS_SW_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_lockout,
  input wire logic thermal_overload,
  input wire logic ref_above_fb,
  input wire logic pwm_end,
  input wire logic valley_cmp,
  input wire logic sink_cmp,
  input wire logic switch_node_neg,
  input wire logic hs_gate_off,
  input wire logic ls_gate_off,
  input wire logic output_good_flag_cmp,
  output logic high_side_drive,
  output logic low_side_drive,
  output logic output_good_flag,
  output logic [6:0] ref_code
);
  localparam int TON_MIN_CYC = (`BFS_TON_MIN_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS;
  localparam logic [11:0] TON_MIN = 12'(TON_MIN_CYC);
  localparam logic [12:0] HIC_LAST = 13'(HICCUP_CYCLES - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Register state
  logic en_r;
  logic [11:0] period_r;
  logic [11:0] maxon_r;
  logic [2:0] evt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // Sequencer state
  bfs_state_t state_r, state_nxt;
  bfs_phase_t phase_r, phase_nxt;
  logic [11:0] pcnt_r;
  logic [11:0] ton_r;
  logic [2:0] oc_r;
  logic [12:0] hic_r;
  logic skip_r;
  logic sink_cut_r;
  logic hs_r;
  logic ls_r;
  logic pg_r;
  logic [6:0] ref_w;
  logic ramp_top;

  // APB decode
  wire acc = psel && penable;
  wire sel_ctrl = hit(paddr, `BFS_CTRL_OFS);
  wire sel_per = hit(paddr, `BFS_PERIOD_OFS);
  wire sel_max = hit(paddr, `BFS_MAXON_OFS);
  wire sel_stat = hit(paddr, `BFS_STATUS_OFS);
  wire sel_evt = hit(paddr, `BFS_EVENT_OFS);
  wire mapped = sel_ctrl | sel_per | sel_max | sel_stat | sel_evt;
  // Write lands only on the edge where the master sees pready high
  wire wr_go = acc && pwrite && pready_r && mapped;
  wire [31:0] status_w = {17'h00000, pg_r, ls_r, hs_r, ref_w, oc_r, state_r};
  wire [31:0] rd_mux = sel_ctrl ? {31'h00000000, en_r} :
                       sel_per ? {20'h00000, period_r} :
                       sel_max ? {20'h00000, maxon_r} :
                       sel_stat ? status_w :
                       sel_evt ? {29'h00000000, evt_r} : 32'h00000000;

  // Switching clock and sampled conditions
  wire tick = (pcnt_r == 12'h000);
  wire [11:0] per_eff = (period_r < 12'h002) ? 12'h002 : period_r;
  wire fault = supply_lockout || thermal_overload;
  wire run_ok = en_r && !fault;
  wire valley_now = (phase_r == BFS_PH_LS) && ls_r && valley_cmp && switch_node_neg;
  wire valley_hit = tick && valley_now;
  wire switching = (state_r == BFS_ST_RUN);
  wire oc_up = valley_hit && oc_r != `BFS_OC_FULL;
  wire oc_down = tick && !valley_now && oc_r != 3'h0;
  wire oc_trip = switching && valley_hit && oc_r == 3'h6;
  wire hic_done = (state_r == BFS_ST_HICCUP) && tick && (hic_r == HIC_LAST);
  wire ramp_restart = !run_ok || hic_done || (state_r == BFS_ST_OFF);
  wire first_pulse = (state_r == BFS_ST_PREBIAS) && tick && ref_above_fb;
  wire start_hs = tick && !valley_now && !skip_r &&
                  (switching || first_pulse);
  wire hs_end = (phase_r == BFS_PH_HS) && (ton_r + 12'h001 >= TON_MIN) &&
                (pwm_end || ton_r + 12'h001 >= maxon_r);
  wire short_req = (phase_r == BFS_PH_HS) && pwm_end && (ton_r + 12'h001 < TON_MIN);
  wire sink_trip = (phase_r == BFS_PH_LS) && ls_r && sink_cmp && !switch_node_neg;

  bfs_ref_ramp #(
    .STEPS(SS_STEPS),
    .SW_CYCLES(SS_CYCLES),
    .CW(7)
  ) u_ramp (
    .core_clk(core_clk),
    .srst(srst),
    .restart(ramp_restart),
    .tick(tick && (state_r == BFS_ST_PREBIAS || switching)),
    .step_down(valley_now && switching),
    .ref_code(ref_w),
    .at_top(ramp_top)
  );

  // Sequence control
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BFS_ST_OFF: begin
        if (run_ok) state_nxt = BFS_ST_PREBIAS;
      end
      BFS_ST_PREBIAS: begin
        if (!run_ok) state_nxt = BFS_ST_OFF;
        else if (first_pulse) state_nxt = BFS_ST_RUN;
      end
      BFS_ST_RUN: begin
        if (!run_ok) state_nxt = BFS_ST_OFF;
        else if (oc_trip) state_nxt = BFS_ST_HICCUP;
      end
      BFS_ST_HICCUP: begin
        if (!run_ok) state_nxt = BFS_ST_OFF;
        else if (hic_done) state_nxt = BFS_ST_PREBIAS;
      end
      default: state_nxt = BFS_ST_OFF;
    endcase
  end

  // Switching phase within a cycle
  always_comb begin
    phase_nxt = phase_r;
    if (!run_ok || state_nxt == BFS_ST_HICCUP || state_r == BFS_ST_OFF) begin
      phase_nxt = BFS_PH_IDLE;
    end else if (start_hs) begin
      phase_nxt = BFS_PH_HS;
    end else if (hs_end) begin
      phase_nxt = BFS_PH_LS;
    end
  end

  // Drives: a side turns on only once the other gate reads off
  wire want_hs = (phase_nxt == BFS_PH_HS);
  wire want_ls = (phase_nxt == BFS_PH_LS) && !sink_cut_r && !sink_trip;
  wire hs_nxt = want_hs && !ls_r && ls_gate_off;
  wire ls_nxt = want_ls && !hs_r && hs_gate_off;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_r <= `BFS_CTRL_RST;
      period_r <= `BFS_PERIOD_RST;
      maxon_r <= `BFS_MAXON_RST;
    end else if (wr_go) begin
      if (sel_ctrl) en_r <= pwdata[0];
      if (sel_per) period_r <= pwdata[11:0];
      if (sel_max) maxon_r <= pwdata[11:0];
    end
  end

  // Sticky events: a new event in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (srst) begin
      evt_r <= 3'h0;
    end else begin
      evt_r <= (evt_r & ~((wr_go && sel_evt) ? pwdata[2:0] : 3'h0)) |
               {valley_hit, oc_trip, sink_trip};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !mapped;
      prdata_r <= (acc && !pready_r && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pcnt_r <= 12'h000;
    end else begin
      pcnt_r <= tick ? per_eff - 12'h001 : pcnt_r - 12'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= BFS_ST_OFF;
      phase_r <= BFS_PH_IDLE;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || ramp_restart) begin
      oc_r <= 3'h0;
    end else if (oc_up) begin
      oc_r <= oc_r + 3'h1;
    end else if (oc_down) begin
      oc_r <= oc_r - 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || state_r != BFS_ST_HICCUP) begin
      hic_r <= 13'h0000;
    end else if (tick) begin
      hic_r <= hic_r + 13'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || start_hs) begin
      ton_r <= 12'h000;
    end else if (phase_r == BFS_PH_HS && hs_r) begin
      // Only real on-time counts, so dead time after a low-side cycle cannot shorten the pulse
      ton_r <= ton_r + 12'h001;
    end
  end

  // A too-short request costs the next pulse rather than a sub-minimum one
  always_ff @(posedge core_clk) begin
    if (srst || !run_ok) begin
      skip_r <= 1'b0;
    end else if (short_req) begin
      skip_r <= 1'b1;
    end else if (tick) begin
      skip_r <= 1'b0;
    end
  end

  // Low side stays off for the rest of the cycle once sink limit cut it
  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      sink_cut_r <= 1'b0;
    end else if (sink_trip) begin
      sink_cut_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      pg_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt && run_ok;
      ls_r <= ls_nxt && run_ok;
      pg_r <= output_good_flag_cmp && run_ok && (state_nxt == BFS_ST_RUN) && ramp_top;
    end
  end

  assign high_side_drive = hs_r;
  assign low_side_drive = ls_r;
  assign output_good_flag = pg_r;
  assign ref_code = ref_w;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule : bfs_sequencer
`default_nettype wire

//--- logic/bfs_cfg.svh
// Offsets, reset values, field positions and timing figures of the fault and drive sequencer
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH
`define BFS_CTRL_OFS 8'h00
`define BFS_PERIOD_OFS 8'h04
`define BFS_MAXON_OFS 8'h08
`define BFS_STATUS_OFS 8'h0c
`define BFS_EVENT_OFS 8'h10
`define BFS_CTRL_RST 1'h0
`define BFS_PERIOD_RST 12'h032
`define BFS_MAXON_RST 12'h02d
`define BFS_EVT_SINK_BIT 0
`define BFS_EVT_HICCUP_BIT 1
`define BFS_EVT_VALLEY_BIT 2
`define BFS_CLK_PERIOD_NS 40
`define BFS_TON_MIN_NS 125
`define BFS_SS_STEPS 64
`define BFS_SS_SW_CYCLES 2048
`define BFS_HICCUP_SW_CYCLES 4096
`define BFS_OC_FULL 3'h7
`endif

//--- logic/bfs_pkg.sv
// Types shared by the fault and drive sequencer
package bfs_pkg;
  typedef enum logic [1:0] {
    BFS_ST_OFF,
    BFS_ST_PREBIAS,
    BFS_ST_RUN,
    BFS_ST_HICCUP
  } bfs_state_t;
  typedef enum logic [1:0] {
    BFS_PH_IDLE,
    BFS_PH_HS,
    BFS_PH_LS
  } bfs_phase_t;
endpackage : bfs_pkg

//--- logic/bfs_ref_ramp.sv
// Soft-start reference ramp with roll-back
`timescale 1ns/1ps
`default_nettype none
module bfs_ref_ramp #(
  parameter int STEPS = 64,
  parameter int SW_CYCLES = 2048,
  parameter int CW = 7
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic restart,
  input wire logic tick,
  input wire logic step_down,
  output logic [CW-1:0] ref_code,
  output logic at_top
);
  localparam int PER_STEP = SW_CYCLES / STEPS;
  localparam logic [CW-1:0] TOP = CW'(STEPS);
  localparam logic [5:0] DIV_LAST = 6'(PER_STEP - 1);
  logic [CW-1:0] ref_r;
  logic [5:0] div_r;
  wire div_wrap = (div_r == DIV_LAST);
  always_ff @(posedge core_clk) begin
    if (srst || restart) begin
      ref_r <= '0;
      div_r <= '0;
    end else if (tick && step_down) begin
      // Roll back one step per limited cycle, floor at zero
      if (ref_r != '0) ref_r <= ref_r - CW'(1);
      div_r <= '0;
    end else if (tick && ref_r != TOP) begin
      div_r <= div_wrap ? 6'h00 : div_r + 6'h01;
      if (div_wrap) ref_r <= ref_r + CW'(1);
    end
  end
  assign ref_code = ref_r;
  assign at_top = (ref_r == TOP);
endmodule : bfs_ref_ramp
`default_nettype wire

//--- sim/bfs_power_stage.sv
// Behavioural MOSFET pair and inductor
`timescale 1ns/1ps
`default_nettype none
module bfs_power_stage (
  input wire logic core_clk,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic short_on,
  input wire logic sink_on,
  output logic hs_gate_off,
  output logic ls_gate_off,
  output logic pwm_end,
  output logic valley_cmp,
  output logic sink_cmp,
  output logic switch_node_neg
);
  // Gates discharge one clock late, so dead time is never zero
  always_ff @(posedge core_clk) begin
    hs_gate_off <= !high_side_drive;
    ls_gate_off <= !low_side_drive;
  end
  // Loop asks for less than the minimum on-time on every pulse
  assign pwm_end = high_side_drive && !hs_gate_off;
  assign switch_node_neg = low_side_drive && !sink_on;
  assign valley_cmp = switch_node_neg && short_on;
  assign sink_cmp = low_side_drive && sink_on;
endmodule : bfs_power_stage
`default_nettype wire

//--- sim/bfs_sequencer_chk.sv
// Port assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic supply_lockout,
  input wire logic thermal_overload,
  input wire logic sink_cmp,
  input wire logic switch_node_neg,
  input wire logic hs_gate_off,
  input wire logic ls_gate_off,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic [6:0] ref_code
);
  wire flt = supply_lockout | thermal_overload;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  lockout_off_a: assert property (supply_lockout |=> !high_side_drive && !low_side_drive)
    else $error("drive in lockout");
  thermal_off_a: assert property (
    thermal_overload [*3] |-> !high_side_drive && !low_side_drive && ref_code == 7'h00)
    else $error("thermal stop not held");
  no_overlap_a: assert property (!(high_side_drive && low_side_drive))
    else $error("both drives on");
  hs_dead_a: assert property ($rose(high_side_drive) |-> $past(ls_gate_off) && !low_side_drive)
    else $error("high side early");
  ls_dead_a: assert property ($rose(low_side_drive) |-> $past(hs_gate_off) && !high_side_drive)
    else $error("low side early");
  sink_cut_a: assert property (low_side_drive && sink_cmp && !switch_node_neg |=> !low_side_drive)
    else $error("low side kept after sink trip");
  min_on_a: assert property ($rose(high_side_drive) |=> (high_side_drive || $past(flt)) [*3])
    else $error("pulse too short");
  ref_step_a: assert property (ref_code > $past(ref_code) |-> ref_code == $past(ref_code) + 7'h01)
    else $error("reference jumped");
  cover property ($rose(high_side_drive));
  cover property (low_side_drive && sink_cmp);
  cover property ($fell(ref_code == 7'h40));
endmodule : bfs_sequencer_chk
bind bfs_sequencer bfs_sequencer_chk u_chk (.core_clk, .srst, .supply_lockout, .thermal_overload, .sink_cmp,
  .switch_node_neg, .hs_gate_off, .ls_gate_off, .high_side_drive, .low_side_drive, .ref_code);
`default_nettype wire

//--- sim/bfs_sequencer_tb.sv
// Self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer_tb;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, supply_lockout = 1'h0, thermal_overload = 1'h0;
  logic ref_above_fb = 1'h0, output_good_flag_cmp = 1'h1, vl = 1'h0, sk = 1'h0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0] ref_code;
  logic pready, pslverr, pwm_end, valley_cmp, sink_cmp, switch_node_neg, hs_gate_off, ls_gate_off;
  logic high_side_drive, low_side_drive, output_good_flag;
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  // Short hiccup and ramp keep the run brief; ramp ratio stays 2 ticks a step
  bfs_sequencer #(.HICCUP_CYCLES(8), .SS_CYCLES(128)) DUT (.core_clk, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .supply_lockout, .thermal_overload, .ref_above_fb, .pwm_end,
    .valley_cmp, .sink_cmp, .switch_node_neg, .hs_gate_off, .ls_gate_off, .output_good_flag_cmp, .high_side_drive,
    .low_side_drive, .output_good_flag, .ref_code);
  bfs_power_stage PS (.core_clk, .high_side_drive, .low_side_drive, .short_on(vl), .sink_on(sk), .hs_gate_off,
    .ls_gate_off, .pwm_end, .valley_cmp, .sink_cmp, .switch_node_neg);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    chk("pready", 1, pready);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  task automatic quiet(input int len, input string what);
    n = 0;
    repeat (len) begin
      @(posedge core_clk);
      n += {high_side_drive, low_side_drive, output_good_flag} !== 3'h0;
    end
    chk(what, 0, n);
  endtask : quiet
  task automatic hs_rise(input int limit_set_pin);
    n = 0;
    while (high_side_drive !== 1'h0 && n < limit_set_pin) begin
      @(posedge core_clk);
      n++;
    end
    while (high_side_drive !== 1'h1 && n < limit_set_pin) begin
      @(posedge core_clk);
      n++;
    end
  endtask : hs_rise
  task automatic t_regs;
    apb(1'h0, 8'h0c, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'h0, 8'h04, 32'h0);
    chk("period", 32'h32, rd);
    apb(1'h0, 8'h08, 32'h0);
    chk("maxon", 32'h2d, rd);
    apb(1'h0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {rd[30:0], perr});
    apb(1'h1, 8'h04, 32'ha);
    $display("regs end");
  endtask : t_regs
  task automatic t_start;
    apb(1'h1, 8'h00, 32'h1);
    quiet(100, "prebias");
    ref_above_fb <= 1'h1;
    hs_rise(40);
    chk("first pulse", 1, high_side_drive);
    n = 0;
    while (high_side_drive === 1'h1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk("on clocks", 4, n);
    $display("start end");
  endtask : t_start
  task automatic t_ramp;
    n = 0;
    while (ref_code !== 7'h40 && n < 1600) begin
      @(posedge core_clk);
      n++;
    end
    chk("ramp top", 7'h40, ref_code);
    chk("ramp time", 1, n > 1000);
    repeat (20) @(posedge core_clk);
    chk("good", 1, output_good_flag);
    output_good_flag_cmp <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk("good drop", 0, output_good_flag);
    output_good_flag_cmp <= 1'h1;
    $display("ramp end");
  endtask : t_ramp
  task automatic t_sink;
    n = 0;
    sk <= 1'h1;
    repeat (40) begin
      @(posedge core_clk);
      n += low_side_drive === 1'h1;
    end
    sk <= 1'h0;
    chk("sink low side", 1, n < 10);
    apb(1'h0, 8'h10, 32'h0);
    chk("sink event", 32'h1, rd);
    apb(1'h1, 8'h10, 32'h1);
    apb(1'h0, 8'h10, 32'h0);
    chk("event clear", 32'h0, rd);
    $display("sink end");
  endtask : t_sink
  task automatic t_valley;
    vl <= 1'h1;
    repeat (25) @(posedge core_clk);
    n = 0;
    repeat (20) begin
      @(posedge core_clk);
      n += {high_side_drive, low_side_drive} !== 2'h1;
    end
    chk("valley hold", 0, n);
    apb(1'h0, 8'h0c, 32'h0);
    chk("overload", 1, rd[4:2] != 3'h0 && rd[11:5] < 7'h40);
    n = 0;
    while (low_side_drive === 1'h1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    vl <= 1'h0;
    quiet(60, "hiccup");
    apb(1'h0, 8'h10, 32'h0);
    chk("events", 32'h6, rd);
    repeat (40) @(posedge core_clk);
    apb(1'h0, 8'h0c, 32'h0);
    chk("counter", 3'h0, rd[4:2]);
    t_ramp();
    $display("valley end");
  endtask : t_valley
  task automatic t_fault;
    supply_lockout <= 1'h1;
    repeat (2) @(posedge core_clk);
    quiet(50, "lockout");
    supply_lockout <= 1'h0;
    thermal_overload <= 1'h1;
    repeat (2) @(posedge core_clk);
    quiet(50, "thermal");
    chk("ramp reset", 7'h0, ref_code);
    thermal_overload <= 1'h0;
    hs_rise(100);
    chk("restart", 1, high_side_drive);
    chk("fresh ramp", 1, ref_code < 7'h10);
    $display("fault end");
  endtask : t_fault
  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'h0;
    t_regs();
    t_start();
    t_ramp();
    t_sink();
    t_valley();
    t_fault();
    results();
  end
endmodule : bfs_sequencer_tb
`default_nettype wire
